// File: bench/analog_engine_model.sv
// Analog test engine and output pins beside the block
`timescale 1ns/1ns
module analog_engine_model #(
    parameter int LATENCY = 6
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          analog_test_run,
    input  wire logic                          safe_state_out,
    input  wire logic [14:0]                   fail_mask,
    input  wire logic [2:0]                    stuck_mask,
    output fault_selftest_pkg::analog_result_t analog_result,
    output logic [2:0]                         pin_readback
);
    int steps;
    // Pins low under test unless stuck high; safe pin follows safe_state_out
    assign pin_readback = analog_test_run ? (stuck_mask | {safe_state_out, 2'b00})
                                          : {safe_state_out, 2'b11};
    // One done pulse with the results
    always_ff @(posedge clk)
    begin
        analog_result <= '0;
        if (rst || !analog_test_run)
            steps <= 0;
        else
        begin
            steps <= steps + 1;
            if (steps == LATENCY)
                analog_result <= {1'b1, fail_mask};
        end
    end
endmodule : analog_engine_model

// File: bench/fault_selftest_properties.sv
// Port assertions of the fault counter and self-test block
`timescale 1ns/1ns
`include "fault_selftest_cfg.svh"
module fault_selftest_properties (
    input wire logic                               clk,
    input wire logic                               rst,
    input wire logic                               wb_cyc_i,
    input wire logic                               wb_stb_i,
    input wire logic                               wb_we_i,
    input wire fault_selftest_pkg::fault_events_t  events,
    input wire fault_selftest_pkg::otp_config_t    otp,
    input wire fault_selftest_pkg::analog_result_t analog_result,
    input wire logic                               in_normal_state,
    input wire logic                               in_init_state,
    input wire logic                               analog_test_run,
    input wire logic                               logic_selftest_enable,
    input wire logic                               safe_state_out,
    input wire logic                               deep_failsafe_request,
    input wire logic                               power_down_request,
    input wire logic [3:0]                         fault_count_value
);
    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst);
    logic       quiet;
    logic       grow;
    logic       shrink;
    logic       lkey;
    logic [3:0] cnt;
    assign cnt = fault_count_value;
    assign quiet = !(wb_cyc_i && wb_stb_i && wb_we_i);
    assign grow = quiet && events == 20'h00008 && otp.deep_failsafe_enable
        && !deep_failsafe_request;
    assign shrink = quiet && events == 20'h00004;
    assign lkey = otp.logic_selftest_disable_key == `LOGIC_DISABLE_KEY
        && !(otp.otp_boot_error || otp.otp_crc_error || otp.otp_ecc_error);
    property p_fail_inc; grow |=> cnt == $past(cnt) + 4'h1; endproperty
    a_fail_inc: assert property (p_fail_inc) else $error("failure not counted");
    property p_refresh_dec; shrink && cnt != 4'h0 |=> cnt == $past(cnt) - 4'h1; endproperty
    a_refresh_dec: assert property (p_refresh_dec) else $error("no count down");
    property p_floor; shrink && cnt == 4'h0 |=> cnt == 4'h0; endproperty
    a_floor: assert property (p_floor) else $error("count wrapped");
    property p_core_down; |events[1:0] |=> power_down_request; endproperty
    a_core_down: assert property (p_core_down) else $error("no power down");
    property p_down_holds; power_down_request |=> power_down_request; endproperty
    a_down_holds: assert property (p_down_holds) else $error("power down lost");
    property p_logic_key; $stable(otp) && !$past(rst) |-> logic_selftest_enable == !lkey; endproperty
    a_logic_key: assert property (p_logic_key) else $error("logic test enable wrong");
    property p_analog_off; !otp.analog_selftest_enable |=> !analog_test_run; endproperty
    a_analog_off: assert property (p_analog_off) else $error("analog test ran");
    property p_init_safe; analog_test_run && in_init_state |-> !safe_state_out; endproperty
    a_init_safe: assert property (p_init_safe) else $error("safe output high");
    property p_normal_safe; analog_test_run && in_normal_state |-> safe_state_out; endproperty
    a_normal_safe: assert property (p_normal_safe) else $error("safe output low");
    property p_run_stop; analog_test_run && analog_result.done |=> !analog_test_run; endproperty
    a_run_stop: assert property (p_run_stop) else $error("test kept running");
endmodule : fault_selftest_properties

bind fault_selftest fault_selftest_properties u_props (
    .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .events, .otp, .analog_result,
    .in_normal_state, .in_init_state, .analog_test_run, .logic_selftest_enable,
    .safe_state_out, .deep_failsafe_request, .power_down_request, .fault_count_value
);

// File: bench/tb_fault_selftest.sv
// Self-checking bench of the fault counter and self-test block
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h want %h", $time, got, exp); end end
module tb_fault_selftest;
    fault_selftest_pkg::fault_events_t  ev;
    fault_selftest_pkg::otp_config_t    otp;
    fault_selftest_pkg::analog_result_t ares;
    logic        clk, rst, cyc, stb, we, ack, normal, init, lsd, lso, run, lse, safe, dfr, pdr;
    logic [2:0]  pins, stuck;
    logic [3:0]  cnt, e;
    logic [7:0]  adr;
    logic [14:0] fail;
    logic [31:0] wdat, rdat, q;
    logic [3:0]  lim [4] = '{4'h1, 4'h2, 4'h6, 4'hC};
    int          mismatches = 0;
    int          num_checks = 0;
    fault_selftest u_dut (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .events(ev),
        .otp(otp), .analog_result(ares), .in_normal_state(normal), .in_init_state(init),
        .pin_readback(pins), .logic_selftest_done(lsd), .logic_selftest_ok(lso),
        .analog_test_run(run), .logic_selftest_enable(lse), .safe_state_out(safe),
        .deep_failsafe_request(dfr), .power_down_request(pdr), .fault_count_value(cnt)
    );
    analog_engine_model u_engine (
        .clk(clk), .rst(rst), .analog_test_run(run), .safe_state_out(safe),
        .fail_mask(fail), .stuck_mask(stuck), .analog_result(ares), .pin_readback(pins)
    );
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        q = rdat;
        {cyc, stb, we} <= 3'h0;
        @(negedge clk);
    endtask : wb
    task automatic pulse(input logic [19:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= '0;
        @(negedge clk);
    endtask : pulse
    task automatic wait_run(input logic v);
        while (run !== v)
            @(posedge clk);
        @(negedge clk);
    endtask : wait_run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200000;
        mismatches++;
        complete_run;
    end
    initial
    begin
        {rst, init} = 2'h3;
        {cyc, stb, we, lsd, lso, normal, adr, wdat, ev, fail, stuck} = '0;
        otp = '0;
        otp.source_count_enable = 6'h3E;
        otp.over_assigned = 6'h15;
        otp.under_assigned = 6'h2A;
        otp.err_input_count_enable = 2'h3;
        otp.collector_count_enable = 1'b1;
        otp.deep_failsafe_enable = 1'b1;
        otp.analog_selftest_enable = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK(cnt, 4'h0)
        wait_run(1'b1);
        wait_run(1'b0);
        wb(8'h08, 1'b0, 32'h0);
        `CHK(q, 32'h0)
        wb(8'h00, 1'b0, 32'h0);
        `CHK(q[7:0], 8'h01)
        fail = 15'h4A53;
        stuck = 3'h2;
        wb(8'h04, 1'b1, 32'h1);
        wait_run(1'b1);
        `CHK(safe, 1'b0)
        wait_run(1'b0);
        wb(8'h08, 1'b0, 32'h0);
        `CHK(q[17:0], {fail[14:12], stuck, fail[11:0]})
        wb(8'h04, 1'b0, 32'h0);
        `CHK(q[0], 1'b0)
        for (int c = 0; c < 4; c++)
        begin
            wb(8'h00, 1'b1, 32'h4 | c);
            repeat (13) pulse(20'h00008);
            `CHK(cnt, lim[c])
            `CHK(dfr, 1'b1)
        end
        wb(8'h00, 1'b1, 32'hF);
        `CHK(cnt, 4'hC)
        wb(8'h00, 1'b1, 32'h7);
        `CHK(cnt, 4'h0)
        pulse(20'h00004);
        `CHK(cnt, 4'h0)
        repeat (2) pulse(20'h00008);
        pulse(20'h00004);
        `CHK(cnt, 4'h1)
        wb(8'h00, 1'b1, 32'h7);
        e = 4'h0;
        for (int i = 0; i < 6; i++)
        begin
            pulse(20'h04000 << i);
            e += otp.source_count_enable[i] & otp.over_assigned[i];
            `CHK(cnt, e)
            pulse(20'h00100 << i);
            e += otp.source_count_enable[i] & otp.under_assigned[i];
            `CHK(cnt, e)
        end
        pulse(20'h000C0);
        `CHK(cnt, e)
        @(posedge clk);
        {normal, init} <= 2'h2;
        pulse(20'h00040);
        pulse(20'h00080);
        `CHK(cnt, e + 4'h2)
        pulse(20'h00010);
        pulse(20'h00020);
        `CHK(cnt, e + 4'h4)
        {fail, stuck} = '0;
        wb(8'h04, 1'b1, 32'h1);
        wait_run(1'b1);
        `CHK(safe, 1'b1)
        wait_run(1'b0);
        wb(8'h08, 1'b0, 32'h0);
        `CHK(q, 32'h0)
        @(posedge clk);
        {lsd, lso} <= 2'h3;
        @(posedge clk);
        lsd <= 1'b0;
        wb(8'h04, 1'b0, 32'h0);
        `CHK(q[2:1], 2'h3)
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            otp.logic_selftest_disable_key <= (k == 2) ? 8'h37 : 8'h36;
            otp.otp_ecc_error <= (k == 1);
            repeat (3) @(negedge clk);
            `CHK(lse, k != 0)
        end
        @(posedge clk);
        rst <= 1'b1;
        otp.analog_selftest_enable <= 1'b0;
        repeat (4) @(posedge clk);
        {rst, normal, init} <= 3'h1;
        wb(8'h04, 1'b1, 32'h1);
        repeat (5) @(negedge clk);
        `CHK(run, 1'b0)
        pulse(20'h00001);
        `CHK(pdr, 1'b1)
        complete_run;
    end
endmodule : tb_fault_selftest

// File: rtl/fault_selftest.sv
// Fault error counter, analog and logic self-test bookkeeping
`timescale 1ns/1ns
`include "fault_selftest_cfg.svh"

// How it works
// [RULE1] Max sel code maps to 1,2,6,12
// [RULE2] Four-bit count, zero after reset
// [RULE3] Clear only on clear=1 with complement=0
// [RULE4] Refresh at refresh maximum decrements by one
// [RULE5] Each assigned fault occurrence adds one
// [RULE6] Voltage faults need enable and assignment
// [RULE7] Error input faults count only normal
// [RULE8] Collector input faults count when enabled
// [RULE9] Host programs limit once at power-up; the code takes a new max sel on every count control write
// [RULE10] Host clears only with watchdog disabled; the code honours the clear pair with no watchdog check
// [RULE11] Analog test runs only when enabled
// [RULE12] Flags for CRC, oscillator, bandgap
// [RULE13] One flag per comparator, set on failure
// [RULE14] Power-good and safe pins checked low
// [RULE15] Successful test leaves all flags zero
// [RULE16] On-demand bit self-clears when done
// [RULE17] Safe output low for test from init
// [RULE18] Safe output high for test from normal
// [RULE19] Logic test off only with key, no errors
// [RULE20] Pass bit set on successful logic test
// [RULE21] Core supply fault requests power down
// [RULE22] Host reads flags, decides normal entry
// [RULE23] Watchdog failure adds one
// [RULE24] Count at maximum requests deep fail-safe
// [RULE25] Count saturates at maximum and zero
module fault_selftest (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            wb_cyc_i,
    input  wire logic                            wb_stb_i,
    input  wire logic                            wb_we_i,
    input  wire logic [7:0]                      wb_adr_i,
    input  wire logic [3:0]                      wb_sel_i,
    input  wire logic [31:0]                     wb_dat_i,
    output logic      [31:0]                     wb_dat_o,
    output logic                                 wb_ack_o,
    input  wire fault_selftest_pkg::fault_events_t  events,
    input  wire fault_selftest_pkg::otp_config_t    otp,
    input  wire fault_selftest_pkg::analog_result_t analog_result,
    input  wire logic                            in_normal_state,
    input  wire logic                            in_init_state,
    input  wire logic [2:0]                      pin_readback,
    input  wire logic                            logic_selftest_done,
    input  wire logic                            logic_selftest_ok,
    output logic                                 analog_test_run,
    output logic                                 logic_selftest_enable,
    output logic                                 safe_state_out,
    output logic                                 deep_failsafe_request,
    output logic                                 power_down_request,
    output logic [3:0]                           fault_count_value
);

    fault_selftest_pkg::block_state_t s_reg;
    fault_selftest_pkg::block_state_t s_next;

    function automatic logic [3:0] count_max(input logic [1:0] sel);
        case (sel)
            2'h0:    count_max = `MAX_CODE_00; // [RULE1]
            2'h1:    count_max = `MAX_CODE_01; // [RULE1]
            2'h2:    count_max = `MAX_CODE_10; // [RULE1]
            default: count_max = `MAX_CODE_11; // [RULE1]
        endcase
    endfunction : count_max

    function automatic logic [4:0] ones(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++)
        begin
            n = n + {4'h0, v[i]};
        end
        ones = n;
    endfunction : ones

    logic        access;
    logic        wr;
    logic [15:0] inc_vec;
    logic [4:0]  inc_n;
    logic [5:0]  sum;
    logic [3:0]  lim;
    logic [3:0]  base;
    logic        clear_pair;
    logic        dec;
    logic        analog_start;
    logic        od_set;
    logic [31:0] rd;

    always_comb
    begin
        s_next = s_reg;
        access = wb_cyc_i && wb_stb_i && !s_reg.wb_ack;
        wr = access && wb_we_i && wb_sel_i[0];
        rd = 32'h0000_0000;
        clear_pair = 1'b0;
        od_set = 1'b0;
        s_next.wb_ack = access;

        // Pin readback synchroniser
        s_next.pin_sync1 = pin_readback;
        s_next.pin_sync2 = s_reg.pin_sync1;

        // Register writes
        if (wr && wb_adr_i == `OFS_COUNT_CTRL)
        begin
            s_next.fault_count_max_sel = wb_dat_i[`FLD_MAX_SEL_LO +: 2];
            clear_pair = wb_dat_i[`FLD_CLEAR] && !wb_dat_i[`FLD_CLEAR_CMPL]; // [RULE3]
        end
        if (wr && wb_adr_i == `OFS_SELFTEST_CTRL && wb_dat_i[`FLD_OD_REQUEST]
            && (in_normal_state || in_init_state))
        begin
            od_set = 1'b1;
            s_next.selftest_on_demand_request = 1'b1; // [RULE16]
        end

        // Counter sources
        inc_vec = 16'h0000;
        for (int i = 0; i < 6; i++)
        begin
            inc_vec[i] = events.over_fault[i] && otp.source_count_enable[i]
                         && otp.over_assigned[i]; // [RULE6]
            inc_vec[i + 6] = events.under_fault[i] && otp.source_count_enable[i]
                             && otp.under_assigned[i]; // [RULE6]
        end
        for (int i = 0; i < 2; i++)
        begin
            inc_vec[i + 12] = events.error_input_fault[i] && otp.err_input_count_enable[i]
                              && in_normal_state; // [RULE7]
        end
        inc_vec[14] = otp.collector_count_enable
                      && (|events.collector_input_fault); // [RULE8]
        inc_vec[15] = events.watchdog_failure; // [RULE23]
        inc_n = ones(inc_vec); // [RULE5]
        dec = events.watchdog_refresh_at_max; // [RULE4]

        lim = count_max(s_next.fault_count_max_sel);
        base = clear_pair ? 4'h0 : s_reg.fault_count_value; // [RULE3]
        if (base > lim)
        begin
            base = lim;
        end
        sum = {2'h0, base} + {1'h0, inc_n};
        if (dec && sum != 6'h00)
        begin
            sum = sum - 6'h01; // [RULE4] [RULE25]
        end
        if (sum > {2'h0, lim})
        begin
            sum = {2'h0, lim}; // [RULE25]
        end
        s_next.fault_count_value = sum[3:0]; // [RULE2] [RULE5]
        s_next.deep_failsafe_request = otp.deep_failsafe_enable
                                       && s_next.fault_count_value == lim; // [RULE24]
        s_next.power_down_request = s_reg.power_down_request
                                    || events.core_over_fault
                                    || events.core_under_fault; // [RULE21]

        // Analog self-test sequencer
        analog_start = otp.analog_selftest_enable
                       && (s_reg.boot_test_pending || s_reg.selftest_on_demand_request); // [RULE11]
        s_next.analog_test_run = 1'b0;
        case (s_reg.test_state)
            fault_selftest_pkg::ST_IDLE:
            begin
                if (!otp.analog_selftest_enable)
                begin
                    s_next.boot_test_pending = 1'b0; // [RULE11]
                    s_next.selftest_on_demand_request = 1'b0; // [RULE11]
                end
                else if (analog_start)
                begin
                    s_next.flags = '0; // [RULE15]
                    s_next.started_in_normal = in_normal_state
                                               && !s_reg.boot_test_pending;
                    s_next.analog_test_run = 1'b1;
                    s_next.test_state = fault_selftest_pkg::ST_RUN;
                end
            end
            fault_selftest_pkg::ST_RUN:
            begin
                s_next.analog_test_run = 1'b1;
                if (analog_result.done)
                begin
                    // Pins checked at done, after the synchroniser has settled
                    if (!s_reg.started_in_normal)
                    begin
                        s_next.flags.pin_stuck_high_flag = s_reg.pin_sync2; // [RULE14]
                    end
                    s_next.flags.mirror_crc_error_flag = analog_result.crc_error; // [RULE12]
                    s_next.flags.oscillator_error_flag = analog_result.osc_error; // [RULE12]
                    s_next.flags.bandgap_mismatch_flag = analog_result.bandgap_error; // [RULE12]
                    s_next.flags.over_test_flag = analog_result.over_comp_fail; // [RULE13]
                    s_next.flags.under_test_flag = analog_result.under_comp_fail; // [RULE13]
                    s_next.analog_test_run = 1'b0;
                    s_next.test_state = fault_selftest_pkg::ST_DONE;
                end
            end
            fault_selftest_pkg::ST_DONE:
            begin
                s_next.boot_test_pending = 1'b0;
                s_next.selftest_on_demand_request = od_set; // [RULE16]
                s_next.test_state = fault_selftest_pkg::ST_IDLE;
            end
            default:
            begin
                s_next.test_state = fault_selftest_pkg::ST_IDLE;
            end
        endcase

        // Safe-state output
        if (s_next.test_state != fault_selftest_pkg::ST_IDLE)
        begin
            s_next.safe_state_out = s_next.started_in_normal; // [RULE17] [RULE18]
        end
        else
        begin
            s_next.safe_state_out = in_normal_state;
        end

        // Logic self-test
        s_next.logic_selftest_enable = !(otp.logic_selftest_disable_key == `LOGIC_DISABLE_KEY
                                         && !otp.otp_boot_error && !otp.otp_crc_error
                                         && !otp.otp_ecc_error); // [RULE19]
        if (s_reg.logic_selftest_enable && logic_selftest_done && logic_selftest_ok)
        begin
            s_next.logic_selftest_pass = 1'b1; // [RULE20]
        end

        // Register reads
        case (wb_adr_i)
            `OFS_COUNT_CTRL:
            begin
                rd[`FLD_MAX_SEL_LO +: 2] = s_reg.fault_count_max_sel;
                rd[`FLD_COUNT_LO +: 4] = s_reg.fault_count_value;
            end
            `OFS_SELFTEST_CTRL:
            begin
                rd[`FLD_OD_REQUEST] = s_reg.selftest_on_demand_request;
                rd[`FLD_LOGIC_PASS] = s_reg.logic_selftest_pass;
                rd[`FLD_LOGIC_ENABLE] = s_reg.logic_selftest_enable;
                rd[`FLD_ANALOG_BUSY] = s_reg.test_state != fault_selftest_pkg::ST_IDLE;
            end
            `OFS_ANALOG_FLAGS:
            begin
                rd[17:0] = s_reg.flags; // [RULE22]
            end
            default:
            begin
                rd = 32'h0000_0000;
            end
        endcase
        s_next.wb_dat = (access && !wb_we_i) ? rd : 32'h0000_0000;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.fault_count_max_sel <= `RST_MAX_SEL; // [RULE1]
            s_reg.fault_count_value <= 4'h0; // [RULE2]
            s_reg.boot_test_pending <= 1'b1;
            s_reg.logic_selftest_enable <= 1'b1;
            s_reg.test_state <= fault_selftest_pkg::ST_IDLE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign wb_dat_o = s_reg.wb_dat;
    assign wb_ack_o = s_reg.wb_ack;
    assign analog_test_run = s_reg.analog_test_run;
    assign logic_selftest_enable = s_reg.logic_selftest_enable;
    assign safe_state_out = s_reg.safe_state_out;
    assign deep_failsafe_request = s_reg.deep_failsafe_request;
    assign power_down_request = s_reg.power_down_request;
    assign fault_count_value = s_reg.fault_count_value;

endmodule : fault_selftest

// File: rtl/fault_selftest_cfg.svh
// Offsets, field positions, reset values and codes of the fault and self-test block
`ifndef FAULT_SELFTEST_CFG_SVH
`define FAULT_SELFTEST_CFG_SVH

`define OFS_COUNT_CTRL    8'h00
`define OFS_SELFTEST_CTRL 8'h04
`define OFS_ANALOG_FLAGS  8'h08

`define FLD_MAX_SEL_LO    0
`define FLD_CLEAR         2
`define FLD_CLEAR_CMPL    3
`define FLD_COUNT_LO      4
`define FLD_OD_REQUEST    0
`define FLD_LOGIC_PASS    1
`define FLD_LOGIC_ENABLE  2
`define FLD_ANALOG_BUSY   3

`define RST_MAX_SEL       2'h1
`define MAX_CODE_00       4'h1
`define MAX_CODE_01       4'h2
`define MAX_CODE_10       4'h6
`define MAX_CODE_11       4'hC
`define LOGIC_DISABLE_KEY 8'h36
`define OSC_TOL_PCT       15
`define BANDGAP_TOL_PCT   12

`endif

// File: rtl/fault_selftest_pkg.sv
// Types of the fault and self-test block
package fault_selftest_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} test_state_t;

    // Index 0,1 regulators; 2..5 external monitors
    typedef struct packed {
        logic [5:0] over_fault;
        logic [5:0] under_fault;
        logic [1:0] error_input_fault;
        logic [1:0] collector_input_fault;
        logic       watchdog_failure;
        logic       watchdog_refresh_at_max;
        logic       core_over_fault;
        logic       core_under_fault;
    } fault_events_t;

    typedef struct packed {
        logic [5:0] source_count_enable;
        logic [5:0] over_assigned;
        logic [5:0] under_assigned;
        logic [1:0] err_input_count_enable;
        logic       collector_count_enable;
        logic       deep_failsafe_enable;
        logic       analog_selftest_enable;
        logic [7:0] logic_selftest_disable_key;
        logic       otp_boot_error;
        logic       otp_crc_error;
        logic       otp_ecc_error;
    } otp_config_t;

    typedef struct packed {
        logic       done;
        logic       crc_error;
        logic       osc_error;
        logic       bandgap_error;
        logic [5:0] over_comp_fail;
        logic [5:0] under_comp_fail;
    } analog_result_t;

    typedef struct packed {
        logic        mirror_crc_error_flag;
        logic        oscillator_error_flag;
        logic        bandgap_mismatch_flag;
        logic [2:0]  pin_stuck_high_flag;
        logic [5:0]  over_test_flag;
        logic [5:0]  under_test_flag;
    } analog_flags_t;

    typedef struct packed {
        logic [31:0]   wb_dat;
        logic          wb_ack;
        logic [1:0]    fault_count_max_sel;
        logic [3:0]    fault_count_value;
        logic          selftest_on_demand_request;
        logic          boot_test_pending;
        logic          started_in_normal;
        test_state_t   test_state;
        analog_flags_t flags;
        logic [2:0]    pin_sync1;
        logic [2:0]    pin_sync2;
        logic          analog_test_run;
        logic          logic_selftest_enable;
        logic          logic_selftest_pass;
        logic          safe_state_out;
        logic          deep_failsafe_request;
        logic          power_down_request;
    } block_state_t;

endpackage : fault_selftest_pkg
